// File: inc/fsp_pkg.sv
// Constants for the flash self-programming sequencer
package fsp_pkg;
  // Register byte addresses on the APB bus
  localparam logic [11:0] ADDR_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_POINTER = 12'h004;
  localparam logic [11:0] ADDR_DATA = 12'h008;
  localparam logic [11:0] ADDR_STORE = 12'h00C;
  localparam logic [11:0] ADDR_LOAD = 12'h010;
  localparam logic [11:0] ADDR_STATUS = 12'h014;
  // Control field positions
  localparam int BIT_ENABLE = 0;
  localparam int BIT_ERASE = 1;
  localparam int BIT_WRITE = 2;
  localparam int BIT_FUSE = 3;
  localparam int BIT_CLEAR = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Pointer fields
  localparam int PAGE_LSB = 6;
  localparam int PAGE_MSB = 12;
  localparam int WORD_LSB = 1;
  localparam int WORD_MSB = 5;
  localparam int PAGE_W = PAGE_MSB - PAGE_LSB + 1;
  localparam int WORD_W = WORD_MSB - WORD_LSB + 1;
  localparam int BUF_DEPTH = 1 << WORD_W;
  // Fuse and lock pointer addresses
  localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
  localparam logic [15:0] PTR_LOCK = 16'h0001;
  localparam logic [15:0] PTR_FUSE_EXT = 16'h0002;
  localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
  // Timed windows in clock cycles
  localparam logic [2:0] STORE_WINDOW = 3'h4;
  localparam logic [2:0] LOAD_WINDOW = 3'h3;
  // Programming time: 3.2 ms least, 3.4 ms most, clock 8 ns
  localparam int PROG_MIN_NS = 3200000;
  localparam int CLK_NS = 8;
  localparam int PROG_CYCLES = (PROG_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // Sequencer states
  typedef enum logic [3:0]
  {
    FSP_IDLE = 4'h1,
    FSP_ARMED = 4'h2,
    FSP_BUSY = 4'h4,
    FSP_FUSE = 4'h8
  } fsp_state_e;
endpackage

// File: core/fsp_page_buffer.sv
// Temporary page buffer with valid flags and registered read
`timescale 1ns/1ps
module fsp_page_buffer
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstN,
  // Write side
  input wire logic wrEn,
  input wire logic [fsp_pkg::WORD_W-1:0] wrIdx,
  input wire logic [15:0] wrData,
  input wire logic clearAll,
  // Read side
  input wire logic [fsp_pkg::WORD_W-1:0] rdIdx,
  output logic [15:0] rdData,
  output logic rdValid
);
  import fsp_pkg::*;
  logic [15:0] mem [BUF_DEPTH];
  logic [BUF_DEPTH-1:0] valid;

  // Any index accepted in any order
  always_ff @(posedge clk)
  begin
    if (wrEn)
    begin
      mem[wrIdx] <= wrData;
    end
  end

  // Valid flags; clearing drops the flags, so stored words read as erased
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      valid <= '0;
    end
    else if (clearAll)
    begin
      valid <= '0;
    end
    else if (wrEn)
    begin
      valid[wrIdx] <= 1'b1;
    end
  end

  // Registered read, unloaded words read as erased
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      rdData <= 16'hFFFF;
      rdValid <= 1'b0;
    end
    else
    begin
      rdData <= valid[rdIdx] ? mem[rdIdx] : 16'hFFFF;
      rdValid <= valid[rdIdx];
    end
  end
endmodule // fsp_page_buffer

// File: core/fsp_sequencer.sv
// Flash self-programming sequencer with APB register access
// Function
// - Erase command then store within four cycles
// - Core halted during erase and write
// - Load command stores data at word index
// - Buffer clears after write, clear bit, reset
// - EEPROM write during loading discards buffer
// - Write command programs page from buffer
// - Buffer words load in any order
// - Load reads bytes selected by pointer bit 0
// - EEPROM busy blocks commands and fuse reads
// - Fuse-read mode returns lock bits via load
// - Fuse-read bits clear on read or timeout
// - Pointer selects fuse low, high, extended
// - Programmed bits read zero, unprogrammed one
// - Cleared mode gives ordinary flash reads
// - Reset aborts a running write
// - Store accepted from any flash location
// - Command bits clear on completion or timeout
// - Erase and write last 3.2 to 3.4 ms
`timescale 1ns/1ps
module fsp_sequencer
#(
  parameter int PROG_TIME_CYCLES = fsp_pkg::PROG_CYCLES
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // EEPROM writer status
  input wire logic eeprom_write_busy,
  // Non-volatile bytes, programmed bit is 0
  input wire logic [7:0] fuse_low_byte,
  input wire logic [7:0] fuse_high_byte,
  input wire logic [7:0] fuse_extended_byte,
  input wire logic [7:0] lock_bits,
  // Flash array port
  output logic flashErase,
  output logic flashWrite,
  output logic [fsp_pkg::PAGE_W-1:0] flashPage,
  output logic [fsp_pkg::WORD_W-1:0] flashWordIdx,
  output logic [15:0] flashWordData,
  input wire logic [15:0] flashReadWord,
  output logic [15:0] flashReadAddr,
  // Core halt
  output logic cpuHalt
);
  import fsp_pkg::*;

  logic rstMeta;
  logic rstSync;
  fsp_state_e state;
  logic [7:0] control;
  logic [15:0] pointer;
  logic [15:0] dataPair;
  logic [2:0] window;
  logic [31:0] progCount;
  logic progWrite;
  logic [15:0] bufRdData;
  logic bufRdValid;
  logic loadingActive;
  logic eeDuringLoad;
  logic bufClear;
  logic bufWr;
  logic [7:0] loadByte;
  logic accessDone;
  logic wrCtrl;
  logic wrStore;
  logic rdLoad;
  logic [WORD_W-1:0] drainIdx;

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // Access accepted in first access cycle, pready completes it one cycle later
  assign accessDone = psel && penable && !pready;
  assign wrCtrl = accessDone && pwrite && (paddr == ADDR_CONTROL);
  assign wrStore = accessDone && pwrite && (paddr == ADDR_STORE);
  assign rdLoad = accessDone && !pwrite && (paddr == ADDR_LOAD);

  // Store in armed state with plain enable is a word load
  assign bufWr = (state == FSP_ARMED) && wrStore && !control[BIT_ERASE]
    && !control[BIT_WRITE] && !eeprom_write_busy;
  // EEPROM write while a fill is underway drops the buffer
  assign eeDuringLoad = eeprom_write_busy && loadingActive;
  assign bufClear = eeDuringLoad || (progWrite && state == FSP_BUSY
    && progCount == 32'(PROG_TIME_CYCLES - 1))
    || (wrCtrl && pwdata[BIT_CLEAR] && !eeprom_write_busy);
  // Read one word ahead so each word meets its own index at the flash port
  assign drainIdx = (state == FSP_BUSY) ? WORD_W'(progCount + 32'h1) : '0;

  // Fill in progress from first load until buffer clears
  always_ff @(posedge core_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      loadingActive <= 1'b0;
    end
    else if (bufClear)
    begin
      loadingActive <= 1'b0;
    end
    else if (bufWr)
    begin
      loadingActive <= 1'b1;
    end
  end

  // Command state machine with timed windows
  always_ff @(posedge core_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      state <= FSP_IDLE;
      control <= CTRL_RESET;
      window <= 3'h0;
      progCount <= WORD_ZERO;
      progWrite <= 1'b0;
      flashPage <= '0;
    end
    else
    begin
      unique case (state)
        FSP_IDLE:
        begin
          // EEPROM busy blocks all commands and fuse reads
          if (wrCtrl && pwdata[BIT_ENABLE] && !eeprom_write_busy)
          begin
            control <= pwdata[7:0] & 8'h0F;
            if (pwdata[BIT_FUSE])
            begin
              state <= FSP_FUSE;
              window <= LOAD_WINDOW;
            end
            else
            begin
              state <= FSP_ARMED;
              window <= STORE_WINDOW;
            end
          end
        end
        FSP_ARMED:
        begin
          if (wrStore && !eeprom_write_busy)
          begin
            if (control[BIT_ERASE] || control[BIT_WRITE])
            begin
              // Page from pointer bits, other bits ignored
              flashPage <= pointer[PAGE_MSB:PAGE_LSB];
              progWrite <= control[BIT_WRITE];
              progCount <= WORD_ZERO;
              state <= FSP_BUSY;
            end
            else
            begin
              state <= FSP_IDLE;
              control <= CTRL_RESET;
            end
          end
          else if (window == 3'h1 || eeprom_write_busy)
          begin
            state <= FSP_IDLE;
            control <= CTRL_RESET;
          end
          else
          begin
            window <= window - 3'h1;
          end
        end
        FSP_BUSY:
        begin
          // Self-timed; only the power-on reset stops it
          if (progCount == 32'(PROG_TIME_CYCLES - 1))
          begin
            state <= FSP_IDLE;
            control <= CTRL_RESET;
          end
          else
          begin
            progCount <= progCount + 32'h1;
          end
        end
        FSP_FUSE:
        begin
          // Read done, store, or three-cycle window lapse
          if (rdLoad || wrStore || window == 3'h1 || eeprom_write_busy)
          begin
            state <= FSP_IDLE;
            control <= CTRL_RESET;
          end
          else
          begin
            window <= window - 3'h1;
          end
        end
        default:
        begin
          state <= FSP_IDLE;
          control <= CTRL_RESET;
        end
      endcase
    end
  end

  // Core halted for the full erase or write
  always_ff @(posedge core_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      cpuHalt <= 1'b0;
      flashErase <= 1'b0;
      flashWrite <= 1'b0;
    end
    else
    begin
      cpuHalt <= (state == FSP_BUSY);
      flashErase <= (state == FSP_BUSY) && !progWrite;
      flashWrite <= (state == FSP_BUSY) && progWrite;
    end
  end

  // Word index walks the buffer while writing
  always_ff @(posedge core_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      flashWordIdx <= '0;
      flashWordData <= 16'hFFFF;
    end
    else
    begin
      flashWordIdx <= (state == FSP_BUSY) ? progCount[WORD_W-1:0] : '0;
      flashWordData <= bufRdData;
    end
  end

  // Pointer and data pair registers
  always_ff @(posedge core_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      pointer <= 16'h0000;
      dataPair <= 16'h0000;
    end
    else
    begin
      if (accessDone && pwrite && paddr == ADDR_POINTER)
      begin
        pointer <= pwdata[15:0];
      end
      if (accessDone && pwrite && paddr == ADDR_DATA)
      begin
        dataPair <= pwdata[15:0];
      end
    end
  end

  // Load result: fuse bytes in read mode, else flash byte
  always_comb
  begin
    loadByte = pointer[0] ? flashReadWord[15:8] : flashReadWord[7:0];
    if (state == FSP_FUSE && !eeprom_write_busy)
    begin
      unique case (pointer)
        PTR_FUSE_LOW: loadByte = fuse_low_byte;
        PTR_LOCK: loadByte = lock_bits;
        PTR_FUSE_EXT: loadByte = fuse_extended_byte;
        PTR_FUSE_HIGH: loadByte = fuse_high_byte;
        default: loadByte = 8'hFF;
      endcase
    end
  end

  // Flash read word address from pointer
  always_ff @(posedge core_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      flashReadAddr <= 16'h0000;
    end
    else
    begin
      flashReadAddr <= {1'b0, pointer[15:1]};
    end
  end

  // APB answer, one wait state
  always_ff @(posedge core_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= WORD_ZERO;
    end
    else
    begin
      pready <= accessDone;
      pslverr <= 1'b0;
      prdata <= WORD_ZERO;
      if (accessDone && !pwrite)
      begin
        unique case (paddr)
          ADDR_CONTROL: prdata <= {24'h0, control};
          ADDR_POINTER: prdata <= {16'h0, pointer};
          ADDR_DATA: prdata <= {16'h0, dataPair};
          ADDR_STORE: prdata <= WORD_ZERO;
          ADDR_LOAD: prdata <= {24'h0, loadByte};
          ADDR_STATUS: prdata <= {28'h0, bufRdValid, loadingActive,
            eeprom_write_busy, cpuHalt};
          default: pslverr <= 1'b1;
        endcase
      end
      else if (accessDone)
      begin
        pslverr <= !(paddr == ADDR_CONTROL || paddr == ADDR_POINTER
          || paddr == ADDR_DATA || paddr == ADDR_STORE);
      end
    end
  end

  // Temporary page buffer
  fsp_page_buffer u_buffer
  (
    .clk(core_clk),
    .rstN(rstSync),
    .wrEn(bufWr),
    .wrIdx(pointer[WORD_MSB:WORD_LSB]),
    .wrData(dataPair),
    .clearAll(bufClear),
    .rdIdx(drainIdx),
    .rdData(bufRdData),
    .rdValid(bufRdValid)
  );
endmodule // fsp_sequencer

// File: verif/fsp_monitor.sv
// Port assertions for the self-programming sequencer
`timescale 1ns/1ps
module fsp_monitor
#(
  parameter int PROG_TIME_CYCLES = 40
)
(
  // Clock, reset and bus
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Flash and core side
  input wire logic eeprom_write_busy,
  input wire logic flashErase,
  input wire logic flashWrite,
  input wire logic [fsp_pkg::PAGE_W-1:0] flashPage,
  input wire logic cpuHalt
);
  import fsp_pkg::*;
  int haltCnt;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Halt length, cleared between operations so each is timed alone
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      haltCnt <= 0;
    else if (cpuHalt)
      haltCnt <= haltCnt + 1;
    else
      haltCnt <= 0;
  end
  chk_ready_once: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_erase_halt: assert property (flashErase |-> cpuHalt)
    else $error("erase without halt");
  chk_write_halt: assert property (flashWrite |-> cpuHalt)
    else $error("write without halt");
  chk_op_alone: assert property (!(flashErase && flashWrite))
    else $error("erase and write together");
  chk_ee_block: assert property ($rose(cpuHalt) |-> !$past(eeprom_write_busy, 2))
    else $error("operation started while eeprom busy");
  chk_halt_len: assert property ($fell(cpuHalt) |->
    haltCnt >= PROG_TIME_CYCLES - 1 && haltCnt <= PROG_TIME_CYCLES + 1)
    else $error("programming time off");
  chk_page_held: assert property (cpuHalt && $past(cpuHalt) |-> $stable(flashPage))
    else $error("page moved during operation");
endmodule // fsp_monitor

bind fsp_sequencer fsp_monitor #(.PROG_TIME_CYCLES(PROG_TIME_CYCLES)) mon
(
  .core_clk(core_clk),
  .rst_n(rst_n),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .pslverr(pslverr),
  .eeprom_write_busy(eeprom_write_busy),
  .flashErase(flashErase),
  .flashWrite(flashWrite),
  .flashPage(flashPage),
  .cpuHalt(cpuHalt)
);

// File: verif/fsp_flash_model.sv
// Behavioural flash array behind the sequencer
`timescale 1ns/1ps
module fsp_flash_model
(
  // Clock
  input wire logic core_clk,
  // Program side
  input wire logic flashWrite,
  input wire logic [fsp_pkg::WORD_W-1:0] flashWordIdx,
  input wire logic [15:0] flashWordData,
  // Read side
  input wire logic [15:0] flashReadAddr,
  output logic [15:0] flashReadWord
);
  import fsp_pkg::*;
  logic [15:0] words [BUF_DEPTH];
  // Content differs per address so a wrong byte lane shows
  assign flashReadWord = {flashReadAddr[7:0] ^ 8'h5A, flashReadAddr[7:0]};
  // Capture each word the sequencer walks out
  always @(posedge core_clk)
  begin
    if (flashWrite)
      words[flashWordIdx] <= flashWordData;
  end
endmodule // fsp_flash_model

// File: verif/tb.sv
// Self-checking testbench for the self-programming sequencer
`timescale 1ns/1ps
module tb;
  import fsp_pkg::*;
  localparam int PROG = 40;
  logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, eeBusy = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, flashErase, flashWrite, cpuHalt;
  logic [PAGE_W-1:0] flashPage;
  logic [WORD_W-1:0] flashWordIdx;
  logic [15:0] flashWordData, flashReadWord, flashReadAddr;
  int mismatches = 0, tests_run = 0, cycles = 0;
  // Device and flash array
  fsp_sequencer #(.PROG_TIME_CYCLES(PROG)) uut (.core_clk(core_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .eeprom_write_busy(eeBusy),
    .fuse_low_byte(8'h1E), .fuse_high_byte(8'h2D), .fuse_extended_byte(8'h4B),
    .lock_bits(8'h87), .flashErase(flashErase), .flashWrite(flashWrite),
    .flashPage(flashPage), .flashWordIdx(flashWordIdx), .flashWordData(flashWordData),
    .flashReadWord(flashReadWord), .flashReadAddr(flashReadAddr), .cpuHalt(cpuHalt));
  fsp_flash_model flash (.core_clk(core_clk), .flashWrite(flashWrite),
    .flashWordIdx(flashWordIdx), .flashWordData(flashWordData),
    .flashReadAddr(flashReadAddr), .flashReadWord(flashReadWord));
  // Clock and hang guard
  initial
  begin
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Request held until pready; caller releases with idle
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
  endtask
  task idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // Control write and store as back-to-back transfers
  task cmd(input logic [15:0] ptr, input logic [15:0] dat, input logic [7:0] ctl);
    apb(1, ADDR_POINTER, {16'h0, ptr});
    apb(1, ADDR_DATA, {16'h0, dat});
    apb(1, ADDR_CONTROL, {24'h0, ctl});
    apb(1, ADDR_STORE, 32'h0);
    idle();
  endtask
  task run_op(input logic [15:0] ptr, input logic [7:0] ctl);
    int n;
    cmd(ptr, 16'h0, ctl);
    for (n = 0; n < 8 && cpuHalt !== 1'b1; n++) @(posedge core_clk);
    chk("cpuHalt", 1, cpuHalt);
    chk("erase", ctl[BIT_ERASE], flashErase);
    chk("write", ctl[BIT_WRITE], flashWrite);
    chk("page", ptr[PAGE_MSB:PAGE_LSB], flashPage);
    apb(0, ADDR_CONTROL, 0);
    idle();
    chk("busy control", {24'h0, ctl}, rd);
    for (n = 0; n < PROG + 20 && cpuHalt !== 1'b0; n++) @(posedge core_clk);
    apb(0, ADDR_CONTROL, 0);
    idle();
    chk("control", 0, rd[7:0]);
  endtask
  task t_fuse;
    logic [15:0] p [4] = '{PTR_FUSE_LOW, PTR_LOCK, PTR_FUSE_EXT, PTR_FUSE_HIGH};
    logic [7:0] e [4] = '{8'h1E, 8'h87, 8'h4B, 8'h2D};
    for (int i = 0; i < 4; i++)
    begin
      apb(1, ADDR_POINTER, {16'h0, p[i]});
      apb(1, ADDR_CONTROL, 32'h09);
      apb(0, ADDR_LOAD, 0);
      idle();
      chk("fuse", e[i], rd[7:0]);
    end
    apb(0, ADDR_CONTROL, 0);
    idle();
    chk("control", 0, rd[7:0]);
    apb(1, ADDR_POINTER, 32'h5);
    apb(0, ADDR_LOAD, 0);
    idle();
    chk("load", 8'h58, rd[7:0]);
    $display("fuse and load test done");
  endtask
  task t_prog;
    run_op(16'h0147, 8'h03);
    cmd(16'h0006, 16'h1234, 8'h01);
    cmd(16'h0000, 16'hBEEF, 8'h01);
    run_op(16'h0140, 8'h05);
    chk("word3", 16'h1234, flash.words[3]);
    chk("word0", 16'hBEEF, flash.words[0]);
    run_op(16'h0140, 8'h05);
    chk("cleared", 16'hFFFF, flash.words[0]);
    cmd(16'h0004, 16'h5555, 8'h01);
    eeBusy <= 1'b1;
    repeat (2) @(posedge core_clk);
    eeBusy <= 1'b0;
    run_op(16'h0140, 8'h05);
    chk("discard", 16'hFFFF, flash.words[2]);
    $display("program test done");
  endtask
  // Clear bit drops a partly filled buffer
  task t_clear;
    cmd(16'h0002, 16'hA5A5, 8'h01);
    apb(0, ADDR_STATUS, 0);
    chk("loading", 1, rd[2]);
    apb(1, ADDR_CONTROL, 32'h10);
    apb(0, ADDR_STATUS, 0);
    idle();
    chk("load ended", 0, rd[2]);
    run_op(16'h0140, 8'h05);
    chk("clear bit", 16'hFFFF, flash.words[1]);
    $display("clear test done");
  endtask
  task t_refuse;
    apb(0, 12'h018, 0);
    idle();
    chk("pslverr", 1, err);
    eeBusy <= 1'b1;
    cmd(16'h0140, 16'h0, 8'h03);
    repeat (4) @(posedge core_clk);
    chk("blocked", 0, cpuHalt);
    eeBusy <= 1'b0;
    apb(1, ADDR_CONTROL, 32'h03);
    idle();
    repeat (6) @(posedge core_clk);
    apb(0, ADDR_CONTROL, 0);
    chk("expired", 0, rd[7:0]);
    apb(1, ADDR_STORE, 0);
    idle();
    repeat (3) @(posedge core_clk);
    chk("late store", 0, cpuHalt);
    $display("refusal test done");
  endtask
  // Main sequence
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    apb(0, ADDR_CONTROL, 0);
    idle();
    chk("reset control", 0, rd);
    t_fuse();
    t_prog();
    t_refuse();
    t_clear();
    print_verdict();
  end
endmodule // tb
